// ---- inc/wce_pkg.sv ----
// package for the watchdog-clear / complement / decrement execution block
package wce_pkg;

  // ---------------------------------------------------------------
  // instruction word layout
  // ---------------------------------------------------------------
  localparam int IW_W    = 14;
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DST_POS = 7;
  localparam int FA_MSB  = 6;
  localparam int FA_W    = 7;
  localparam int DW      = 8;

  // ---------------------------------------------------------------
  // encodings and constants
  // ---------------------------------------------------------------
  localparam logic [13:0] WDCLR_WORD = 14'h0064;
  localparam logic [5:0]  COMP_OPC   = 6'h09;
  localparam logic [5:0]  DECR_OPC   = 6'h03;
  localparam logic [7:0]  WD_CLR_VAL = 8'h00;
  localparam logic [7:0]  PSC_CLR_VAL = 8'h00;
  localparam logic [7:0]  ONE_VAL    = 8'h01;
  localparam logic [7:0]  DATA_RST   = 8'h00;

  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } wce_q_t;

  // kind of instruction held in the decode latch
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_WDCLR = 2'b01,
    OP_COMP  = 2'b10,
    OP_DECR  = 2'b11
  } wce_op_t;

  // file-register read request
  typedef struct packed {
    logic            rd;
    logic [FA_W-1:0] addr;
  } wce_frd_t;

  // destination write results
  typedef struct packed {
    logic            w_we;
    logic            f_we;
    logic [FA_W-1:0] f_addr;
    logic [DW-1:0]   data;
    logic            z_we;
    logic            z;
  } wce_wr_t;

  // watchdog side effects
  typedef struct packed {
    logic wd_clr;
    logic psc_clr;
    logic to_set;
    logic pd_set;
  } wce_wd_t;

endpackage : wce_pkg

// ---- hw/wce_alu.sv ----
// result and zero-flag unit for complement and decrement
`timescale 1ns/1ps
module wce_alu (
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  input  wire logic                i_load,
  input  wce_pkg::wce_op_t         i_op,
  input  wire logic [7:0]          i_opnd,
  output logic      [7:0]          o_res,
  output logic                     o_zero
);
  import wce_pkg::*;

  logic [7:0] res_ff, nxt_res;
  logic       z_ff, nxt_z;

  // ---------------------------------------------------------------
  // compute in q3, result held in a register for q4
  // ---------------------------------------------------------------
  always_comb begin
    nxt_res = res_ff;
    nxt_z   = z_ff;
    if (i_load) begin
      case (i_op)
        OP_COMP: nxt_res = ~i_opnd;                      // RULE_03
        OP_DECR: nxt_res = 8'(i_opnd - ONE_VAL);         // RULE_04
        default: nxt_res = i_opnd;
      endcase
      nxt_z = (nxt_res == DATA_RST);                     // RULE_07
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_ff <= DATA_RST;
      z_ff   <= 1'b0;
    end else begin
      res_ff <= nxt_res;
      z_ff   <= nxt_z;
    end
  end

  assign o_res  = res_ff;
  assign o_zero = z_ff;

endmodule : wce_alu

// ---- hw/wce_exec.sv ----
// execution of watchdog clear, complement file and decrement file
//
// How it works
// RULE_01 - watchdog clear zeroes counter, prescaler; sets timeout, powerdown
// RULE_02 - watchdog clear: decode q1, idle q2, process q3, clear in q4
// RULE_03 - complement: opcode 00 1001, d bit, 7-bit address; writes inverse
// RULE_04 - decrement: opcode 00 0011, d bit, 7-bit address; writes value-1
// RULE_05 - address 0..127; d=0 writes working register, d=1 the file register
// RULE_06 - one cycle: decode q1, read q2, compute q3, write q4
// RULE_07 - zero flag set when 8-bit result is zero, else cleared
`timescale 1ns/1ps
module wce_exec (
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_start,
  input  wire logic [13:0]            i_instr,
  input  wire logic [7:0]             i_fdata,
  output wce_pkg::wce_frd_t           o_frd,
  output wce_pkg::wce_wr_t            o_wr,
  output wce_pkg::wce_wd_t            o_wd,
  output wce_pkg::wce_q_t             o_phase,
  output logic                        o_busy
);
  import wce_pkg::*;

  // ---------------------------------------------------------------
  // reset release through two flops
  // ---------------------------------------------------------------
  logic rst_s1_ff, rst_s2_ff, rstn;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rstn = rst_s2_ff;

  // decoder shared by start and assertions
  function automatic wce_op_t dec_op(input logic [13:0] w);
    if (w == WDCLR_WORD)
      dec_op = OP_WDCLR;
    else if (w[OPC_MSB:OPC_LSB] == COMP_OPC)             // RULE_03
      dec_op = OP_COMP;
    else if (w[OPC_MSB:OPC_LSB] == DECR_OPC)             // RULE_04
      dec_op = OP_DECR;
    else
      dec_op = OP_NONE;
  endfunction : dec_op

  // ---------------------------------------------------------------
  // quarter phase sequencer and decode latch
  // ---------------------------------------------------------------
  wce_q_t         q_ff, nxt_q;
  logic           busy_ff, nxt_busy;
  wce_op_t        op_ff, nxt_op;
  logic           dst_ff, nxt_dst;
  logic [6:0]     fa_ff, nxt_fa;
  logic [7:0]     opnd_ff, nxt_opnd;

  // start is only taken when idle; a busy start is ignored
  always_comb begin
    nxt_q    = q_ff;
    nxt_busy = busy_ff;
    nxt_op   = op_ff;
    nxt_dst  = dst_ff;
    nxt_fa   = fa_ff;
    nxt_opnd = opnd_ff;
    if (!busy_ff) begin
      if (i_start) begin
        nxt_busy = 1'b1;                                 // q1 decode
        nxt_q    = Q2;
        nxt_op   = dec_op(i_instr);                      // RULE_02
        nxt_dst  = i_instr[DST_POS];                     // RULE_05
        nxt_fa   = i_instr[FA_MSB:0];                    // RULE_05
      end
    end else begin
      case (q_ff)
        Q2: begin
          nxt_q = Q3;
          if (op_ff == OP_COMP || op_ff == OP_DECR)
            nxt_opnd = i_fdata;                          // RULE_06
        end
        Q3: nxt_q = Q4;
        Q4: begin
          nxt_q    = Q1;
          nxt_busy = 1'b0;
        end
        default: nxt_q = Q1;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff    <= Q1;
      busy_ff <= 1'b0;
      op_ff   <= OP_NONE;
      dst_ff  <= 1'b0;
      fa_ff   <= 7'h00;
      opnd_ff <= 8'h00;
    end else begin
      q_ff    <= nxt_q;
      busy_ff <= nxt_busy;
      op_ff   <= nxt_op;
      dst_ff  <= nxt_dst;
      fa_ff   <= nxt_fa;
      opnd_ff <= nxt_opnd;
    end
  end

  // ---------------------------------------------------------------
  // compute unit, loaded in q3
  // ---------------------------------------------------------------
  logic       alu_load;
  logic [7:0] alu_res;
  logic       alu_z;
  logic       is_file;

  assign is_file  = (op_ff == OP_COMP) || (op_ff == OP_DECR);
  assign alu_load = busy_ff && (q_ff == Q3) && is_file;  // RULE_06

  wce_alu u_alu (
    .i_clk  (i_clk),
    .i_rstn (rstn),
    .i_load (alu_load),
    .i_op   (op_ff),
    .i_opnd (opnd_ff),
    .o_res  (alu_res),
    .o_zero (alu_z)
  );

  // ---------------------------------------------------------------
  // outputs: q2 read, q4 write / watchdog clear
  // ---------------------------------------------------------------
  logic in_q4;
  assign in_q4 = busy_ff && (q_ff == Q4);

  always_comb begin
    o_frd.rd     = busy_ff && (q_ff == Q2) && is_file;   // RULE_06
    o_frd.addr   = fa_ff;
    o_wr.w_we    = in_q4 && is_file && !dst_ff;          // RULE_05
    o_wr.f_we    = in_q4 && is_file && dst_ff;           // RULE_05
    o_wr.f_addr  = fa_ff;
    o_wr.data    = alu_res;
    o_wr.z_we    = in_q4 && is_file;                     // RULE_07
    o_wr.z       = alu_z;
    // only these flags change; others untouched
    o_wd.wd_clr  = in_q4 && (op_ff == OP_WDCLR);         // RULE_01
    o_wd.psc_clr = in_q4 && (op_ff == OP_WDCLR);         // RULE_01
    o_wd.to_set  = in_q4 && (op_ff == OP_WDCLR);         // RULE_01
    o_wd.pd_set  = in_q4 && (op_ff == OP_WDCLR);         // RULE_01
  end

  assign o_phase = busy_ff ? q_ff : Q1;
  assign o_busy  = busy_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rstn);

  a_wd_clear_q4: assert property (                       // RULE_02
    (!busy_ff && i_start && i_instr == WDCLR_WORD)
      |-> ##3 (o_wd.wd_clr && o_wd.to_set && o_wd.pd_set))
    else $error("watchdog clear not in q4");

  a_wd_flags_tied: assert property (                     // RULE_01
    o_wd.wd_clr |-> (o_wd.psc_clr && o_wd.to_set && o_wd.pd_set
                     && !o_wr.w_we && !o_wr.f_we))
    else $error("watchdog clear side effects inconsistent");

  // operand was taken in q2, two edges before the q4 check
  a_comp_result: assert property (                       // RULE_03
    (!busy_ff && i_start && dec_op(i_instr) == OP_COMP)
      ##2 1 |-> ##1 (o_wr.data == ~$past(i_fdata, 2)))
    else $error("complement result wrong");

  // q3 read data is deliberately ignored by the datapath
  a_decr_result: assert property (                       // RULE_04
    (!busy_ff && i_start && dec_op(i_instr) == OP_DECR)
      ##2 1 |-> ##1 (o_wr.data == 8'($past(i_fdata, 2) - 8'h01)))
    else $error("decrement result wrong");

  a_dest_route: assert property (                        // RULE_05
    (!busy_ff && i_start && dec_op(i_instr) inside {OP_COMP, OP_DECR})
      |-> ##3 (o_wr.f_we == $past(i_instr[DST_POS], 3)
               && o_wr.w_we == !$past(i_instr[DST_POS], 3)))
    else $error("destination routing wrong");

  a_read_q2: assert property (                           // RULE_06
    (!busy_ff && i_start && dec_op(i_instr) inside {OP_COMP, OP_DECR})
      |-> ##1 o_frd.rd ##1 !o_frd.rd ##1 o_wr.z_we ##1 !o_busy)
    else $error("read/write phase order wrong");

  a_zero_flag: assert property (                         // RULE_07
    o_wr.z_we |-> (o_wr.z == (o_wr.data == 8'h00)))
    else $error("zero flag mismatch");

  // q1 is the start edge itself, so busy covers q2..q4 only
  a_one_cycle: assert property (                         // RULE_06
    $rose(busy_ff) |-> busy_ff [*3] ##1 !busy_ff)
    else $error("instruction cycle not four phases");

  // a start seen while busy must not disturb the decode latch
  a_latch_hold: assert property (                        // RULE_06
    busy_ff |=> ($stable(op_ff) && $stable(dst_ff) && $stable(fa_ff)))
    else $error("decode latch changed during a cycle");

  // unknown words walk the four phases with every strobe low
  a_unknown_quiet: assert property (                     // RULE_06
    (op_ff == OP_NONE) |-> (!o_frd.rd && !o_wr.w_we && !o_wr.f_we
                            && !o_wr.z_we && !o_wd.wd_clr))
    else $error("unknown word produced a strobe");

  c_wdclr: cover property (o_wd.wd_clr);
  c_none: cover property (busy_ff && q_ff == Q4 && op_ff == OP_NONE);
  c_comp_f: cover property (o_wr.f_we && op_ff == OP_COMP);
  c_decr_w: cover property (o_wr.w_we && op_ff == OP_DECR);
  c_zero: cover property (o_wr.z_we && o_wr.z);

endmodule : wce_exec

// ---- tb/wce_exec_tb.sv ----
// self-checking bench for the watchdog-clear / complement / decrement unit
`timescale 1ns/1ps
module wce_exec_tb;
  import wce_pkg::*;

  logic        i_clk;
  logic        i_rstn;
  logic        i_start;
  logic [13:0] i_instr;
  logic [7:0]  i_fdata;
  wce_frd_t    o_frd;
  wce_wr_t     o_wr;
  wce_wd_t     o_wd;
  wce_q_t      o_phase;
  logic        o_busy;
  int          fails;
  int          n_checks;

  wce_exec u_dut (
    .i_clk   (i_clk),   .i_rstn  (i_rstn),  .i_start (i_start),
    .i_instr (i_instr), .i_fdata (i_fdata), .o_frd   (o_frd),
    .o_wr    (o_wr),    .o_wd    (o_wd),    .o_phase (o_phase),
    .o_busy  (o_busy)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // expected 8-bit result for the two file operations
  function automatic logic [7:0] exp_res(input logic [13:0] iw,
                                         input logic [7:0]  fd);
    return (iw[13:8] == COMP_OPC) ? ~fd : fd - ONE_VAL;
  endfunction : exp_res

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // one full instruction; hold keeps start up through q2 of the busy cycle (must be ignored)
  task automatic run_op(input logic [13:0] iw, input logic [7:0] fd,
                        input logic hold);
    logic       fo;
    logic       wd;
    logic [7:0] r;
    fo = (iw[13:8] == COMP_OPC) || (iw[13:8] == DECR_OPC);
    wd = (iw == WDCLR_WORD);
    r  = exp_res(iw, fd);
    i_start = 1'b1;
    i_instr = iw;
    @(negedge i_clk);
    i_start = hold;
    i_instr = ~iw;
    i_fdata = fd;
    chk("busy q2", {o_busy, o_phase}, {1'b1, Q2});
    chk("read strobe", o_frd.rd, fo);
    if (fo) chk("read addr", o_frd.addr, iw[6:0]);
    @(negedge i_clk);
    i_start = 1'b0;
    // scrambled so a late capture of the operand shows up
    i_fdata = ~fd;
    chk("phase q3", o_phase, Q3);
    chk("early wd", o_wd, 4'h0);
    @(negedge i_clk);
    chk("phase q4", o_phase, Q4);
    chk("wd pulses", o_wd, {4{wd}});
    chk("w write", o_wr.w_we, fo & ~iw[7]);
    chk("f write", o_wr.f_we, fo & iw[7]);
    chk("z write", o_wr.z_we, fo);
    if (fo) begin
      chk("result", o_wr.data, r);
      chk("zero", o_wr.z, r == 8'h00);
      if (iw[7]) chk("f addr", o_wr.f_addr, iw[6:0]);
    end
    @(negedge i_clk);
    chk("idle", {o_busy, o_wd}, 5'h00);
  endtask : run_op

  // ---------------------------------------------------------------
  // clock, hang guard and main sequence
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // the whole run is far shorter; reaching this means a hang
  initial begin
    #200us;
    fails++;
    $display("[ERR] timeout expected end seen hang");
    test_done();
  end

  initial begin : main
    logic [13:0] iw;
    int          k;
    i_rstn   = 1'b0;
    i_start  = 1'b0;
    i_instr  = 14'h0000;
    i_fdata  = 8'h00;
    fails    = 0;
    n_checks = 0;
    void'($urandom(97));
    repeat (8) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_clk);
    // corners: zero results, wrap, top address, near-miss encodings
    run_op(WDCLR_WORD, 8'h5a, 1'b1);
    run_op(14'h0065, 8'h00, 1'b0);
    run_op({DECR_OPC, 1'b1, 7'h7f}, 8'h01, 1'b1);
    run_op({DECR_OPC, 1'b0, 7'h00}, 8'h00, 1'b0);
    run_op({COMP_OPC, 1'b1, 7'h40}, 8'hff, 1'b0);
    run_op({COMP_OPC, 1'b0, 7'h13}, 8'h13, 1'b1);
    run_op({6'h07, 1'b1, 7'h05}, 8'h22, 1'b0);
    run_op(WDCLR_WORD, 8'h00, 1'b0);
    $display("corner tests done");
    // random mix of all kinds, back to back
    for (int i = 0; i < 60; i++) begin
      k  = $urandom_range(0, 3);
      iw = 14'($urandom);
      if (k == 0) iw[13:8] = COMP_OPC;
      if (k == 1) iw[13:8] = DECR_OPC;
      if (k == 2) iw = WDCLR_WORD;
      run_op(iw, 8'($urandom), 1'($urandom));
    end
    $display("random tests done");
    test_done();
  end
endmodule : wce_exec_tb
